//--- rtl/vic_cfg.svh
// register offsets, field positions, reset values and vectors of the vectored interrupt controller
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define VIC_OFF_MASK      12'h000
`define VIC_OFF_CTRL      12'h004
`define VIC_OFF_FORCECLR  12'h008
`define VIC_OFF_ARITH     12'h00C
`define VIC_OFF_MODE      12'h010
`define VIC_OFF_MBMASK    12'h014
`define VIC_OFF_MBSTAT6   12'h018
`define VIC_OFF_MBSTAT7   12'h01C
`define VIC_OFF_VARIANT   12'h020
`define VIC_OFF_STATUS    12'h024
`define VIC_OFF_CORECMD   12'h028
// ----------------------------------------
// fields
// ----------------------------------------
`define VIC_NEST_BIT      4
`define VIC_CMD_ACK_BIT   0
`define VIC_CMD_RTI_BIT   1
`define VIC_SWRST_BIT     0
`define VIC_NSRC          8
`define VIC_MASK_RST      8'h00
`define VIC_CTRL_RST      5'h00
`define VIC_MBMASK_RST    12'h000
`define VIC_DEPTH_STD     4'h7
`define VIC_DEPTH_MB      4'h9
// ----------------------------------------
// vectors
// ----------------------------------------
`define VIC_VEC_RESET     14'h0000
`define VIC_VEC_BASE      14'h0004
`define VIC_VEC_STEP      14'h0004
`endif

//--- rtl/vic_pkg.sv
// types of the vectored interrupt controller
package vic_pkg;
  typedef enum logic [1:0] {
    VIC_VAR_STD    = 2'b00,
    VIC_VAR_MBOX   = 2'b01,
    VIC_VAR_SINGLE = 2'b10
  } vic_variant_t;
  // source slot index in priority order, 0 highest
  typedef enum logic [2:0] {
    VIC_SRC_EXTTOP = 3'd0,
    VIC_SRC_MBWR   = 3'd1,
    VIC_SRC_MBRD   = 3'd2,
    VIC_SRC_ATX    = 3'd3,
    VIC_SRC_ARX    = 3'd4,
    VIC_SRC_BTX    = 3'd5,
    VIC_SRC_BRX    = 3'd6,
    VIC_SRC_TIMER  = 3'd7
  } vic_src_t;
  typedef enum logic [1:0] {
    VIC_AX_IDLE = 2'b00,
    VIC_AX_RESP = 2'b01
  } vic_axst_t;
endpackage : vic_pkg

//--- rtl/vic_ctrl.sv
// vectored interrupt controller with status stack and mailbox interrupt logic
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "vic_cfg.svh"
module vic_ctrl (
  input  wire logic                 sys_clk,        // core clock 40 MHz
  input  wire logic                 rst_n,          // async master reset
  input  wire vic_pkg::vic_variant_t variant,       // device variant strap
  input  wire logic                 pinCfgThree,    // 1: three ext lines, no port b
  input  wire logic                 extIntTop_n,    // dedicated ext line, low active
  input  wire logic                 extInt1_n,      // ext line 1 on port b pins
  input  wire logic                 extInt0_n,      // ext line 0 on port b pins
  input  wire logic                 timerReq,       // timer pulse
  input  wire logic                 portATxReq,     // serial port a transmit pulse
  input  wire logic                 portARxReq,     // serial port a receive pulse
  input  wire logic                 portBTxReq,     // serial port b transmit pulse
  input  wire logic                 portBRxReq,     // serial port b receive pulse
  input  wire logic [5:0]           hostWrStb,      // host wrote data register n
  input  wire logic [5:0]           hostRdStb,      // host read data register n
  input  wire logic                 hostSwRstSet,   // host sets software reset
  input  wire logic [11:0]          s_axi_awaddr,   // write address
  input  wire logic                 s_axi_awvalid,  // write address valid
  output logic                      s_axi_awready,  // write address ready
  input  wire logic [31:0]          s_axi_wdata,    // write data
  input  wire logic [3:0]           s_axi_wstrb,    // write strobes
  input  wire logic                 s_axi_wvalid,   // write data valid
  output logic                      s_axi_wready,   // write data ready
  output logic [1:0]                s_axi_bresp,    // write response
  output logic                      s_axi_bvalid,   // write response valid
  input  wire logic                 s_axi_bready,   // write response ready
  input  wire logic [11:0]          s_axi_araddr,   // read address
  input  wire logic                 s_axi_arvalid,  // read address valid
  output logic                      s_axi_arready,  // read address ready
  output logic [31:0]               s_axi_rdata,    // read data
  output logic [1:0]                s_axi_rresp,    // read response
  output logic                      s_axi_rvalid,   // read valid
  input  wire logic                 s_axi_rready,   // read ready
  output logic                      intPending,     // unmasked request takeable now
  output logic [13:0]               vectorAddr,     // vector of last taken source
  output logic                      vectorLoad,     // one-cycle pc load pulse
  output logic [3:0]                stackLevel,     // status stack fill
  output logic                      stackOvf,       // push into full stack seen
  output logic                      swReset         // mailbox software reset
);
  import vic_pkg::*;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // vector of a slot under a given variant
  function automatic logic [13:0] slotVector(input logic [2:0] s, input vic_variant_t v);
    logic [13:0] idx;
    idx = 14'(s);
    if (s == 3'd0)
      slotVector = `VIC_VEC_BASE;
    else if (v == VIC_VAR_MBOX)
      slotVector = `VIC_VEC_BASE + idx * `VIC_VEC_STEP;
    else
      slotVector = `VIC_VEC_BASE + (idx - 14'd2) * `VIC_VEC_STEP;
  endfunction : slotVector

  // word match: low address bits ignored
  function automatic logic regHit(input logic [11:0] a, input logic [11:0] off);
    regHit = (a[11:2] == off[11:2]);
  endfunction : regHit

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]  intMaskFf;      // int_mask_reg
  logic [4:0]  intCtrlFf;      // int_control_reg: [2:0] edge per line, [4] nest
  logic [15:0] arithFf;        // arith_status_reg
  logic [15:0] modeFf;         // mode_status_reg
  logic [11:0] mbMaskFf;       // mailbox_mask_reg: [5:0] wr, [11:6] rd
  logic [5:0]  mbWrFullFf;     // mailbox_status_regs: host wrote, unread
  logic [5:0]  mbRdDoneFf;     // host completed read
  logic        swResetFf;
  logic [7:0]  latchFf;        // edge-latched requests
  logic [7:0]  activeFf;       // handlers in service
  logic [2:0]  extPrevFf;
  logic [13:0] vecFf;
  logic        vecLoadFf;
  logic        ovfFf;
  logic [3:0]  spFf;
  logic [39:0] stackMem [0:8];

  logic [2:0]  extLvl;
  logic [2:0]  extEdge;
  logic [7:0]  slotAvail;
  logic [7:0]  rawReq;
  logic [7:0]  levelSlot;
  logic [7:0]  masked;
  logic [2:0]  winSlot;
  logic        winValid;
  logic        canTake;
  logic [3:0]  depth;
  logic        mbWrAny;
  logic        mbRdAny;
  logic [7:0]  forceBits;
  logic [7:0]  clearBits;
  logic        ackCmd;
  logic        rtiCmd;
  logic [7:0]  levelCfg;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic        awHeldFf, wHeldFf;
  logic [11:0] awAddrFf;
  logic [31:0] wDataFf;
  logic        doWrite;
  logic [31:0] rdMux;

  assign s_axi_awready = !awHeldFf && !s_axi_bvalid;
  assign s_axi_wready  = !wHeldFf && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite       = awHeldFf && wHeldFf;

  // address and data land in either order
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeldFf     <= 1'b0;
      wHeldFf      <= 1'b0;
      awAddrFf     <= 12'h000;
      wDataFf      <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeldFf <= 1'b1;
        awAddrFf <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeldFf <= 1'b1;
        wDataFf <= s_axi_wdata;
      end
      if (doWrite) begin
        awHeldFf     <= 1'b0;
        wHeldFf      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddrFf > `VIC_OFF_CORECMD) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------
  // write decode
  // --------------------
  // strobes are ignored: registers take whole words, narrow writes are not used by the core
  assign forceBits = (doWrite && regHit(awAddrFf, `VIC_OFF_FORCECLR)) ? wDataFf[15:8] : 8'h00;
  assign clearBits = (doWrite && regHit(awAddrFf, `VIC_OFF_FORCECLR)) ? wDataFf[7:0] : 8'h00;
  assign ackCmd    = doWrite && regHit(awAddrFf, `VIC_OFF_CORECMD) && wDataFf[`VIC_CMD_ACK_BIT];
  assign rtiCmd    = doWrite && regHit(awAddrFf, `VIC_OFF_CORECMD) && wDataFf[`VIC_CMD_RTI_BIT];

  // --------------------
  // read path
  // --------------------
  always_comb begin
    rdMux = 32'h00000000;
    case (s_axi_araddr[11:2])
      `VIC_OFF_MASK     >> 2: rdMux = {24'h000000, intMaskFf};
      `VIC_OFF_CTRL     >> 2: rdMux = {27'h0000000, intCtrlFf};
      `VIC_OFF_ARITH    >> 2: rdMux = {16'h0000, arithFf};
      `VIC_OFF_MODE     >> 2: rdMux = {16'h0000, modeFf};
      `VIC_OFF_MBMASK   >> 2: rdMux = {20'h00000, mbMaskFf};
      `VIC_OFF_MBSTAT6  >> 2: rdMux = {20'h00000, mbRdDoneFf, mbWrFullFf};
      `VIC_OFF_MBSTAT7  >> 2: rdMux = {31'h00000000, swResetFf};
      `VIC_OFF_VARIANT  >> 2: rdMux = {26'h0000000, pinCfgThree, 1'b0, 2'(variant), 2'b00};
      `VIC_OFF_STATUS   >> 2: rdMux = {activeFf, latchFf, 7'h00, winValid, winSlot, 1'b0, spFf};
      default:                rdMux = 32'h00000000;  // force/clear is write-only
    endcase
  end

  // rdata registered: stands while rvalid waits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= (s_axi_araddr > `VIC_OFF_CORECMD) ? 2'b10 : 2'b00;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // return restores mask: handler edits are lost
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      intMaskFf <= `VIC_MASK_RST;
      intCtrlFf <= `VIC_CTRL_RST;
      arithFf   <= 16'h0000;
      modeFf    <= 16'h0000;
      mbMaskFf  <= `VIC_MBMASK_RST;
    end else begin
      if (rtiCmd && spFf != 4'h0) begin
        {arithFf, modeFf, intMaskFf} <= stackMem[spFf - 4'h1];
      end else if (doWrite) begin
        if (regHit(awAddrFf, `VIC_OFF_MASK))   intMaskFf <= wDataFf[7:0];
        if (regHit(awAddrFf, `VIC_OFF_CTRL))   intCtrlFf <= wDataFf[4:0];
        if (regHit(awAddrFf, `VIC_OFF_ARITH))  arithFf   <= wDataFf[15:0];
        if (regHit(awAddrFf, `VIC_OFF_MODE))   modeFf    <= wDataFf[15:0];
        if (regHit(awAddrFf, `VIC_OFF_MBMASK)) mbMaskFf  <= wDataFf[11:0];
      end
    end
  end

  // ----------------------------------------
  // request sources
  // ----------------------------------------
  // ext 1/0 exist only when port b pins are given over to them
  assign extLvl = {!extIntTop_n, pinCfgThree && !extInt1_n, pinCfgThree && !extInt0_n};
  assign depth  = (variant == VIC_VAR_MBOX) ? `VIC_DEPTH_MB : `VIC_DEPTH_STD;

  // absent slots tied off so stray strobes never latch
  always_comb begin
    slotAvail = 8'hFF;
    if (variant != VIC_VAR_MBOX)  slotAvail[2:1] = 2'b00;
    if (variant == VIC_VAR_SINGLE || pinCfgThree && variant == VIC_VAR_SINGLE) slotAvail[4:3] = 2'b00;
  end

  // --------------------
  // edge detect
  // --------------------
  // reset to idle level: no false edge after reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) extPrevFf <= 3'b000;
    else        extPrevFf <= extLvl;
  end
  assign extEdge = extLvl & ~extPrevFf;

  // --------------------
  // mailbox requests
  // --------------------

  assign mbWrAny = |(hostWrStb & mbMaskFf[5:0]);
  assign mbRdAny = |(hostRdStb & mbMaskFf[11:6]);

  // --------------------
  // level lines
  // --------------------
  // level-sensitive ext lines bypass the latch; mailbox slots cannot be forced
  assign levelSlot = {1'b0, ~intCtrlFf[0] & extLvl[0], ~intCtrlFf[1] & extLvl[1], 4'h0, ~intCtrlFf[2] & extLvl[2]};
  // level lines refuse force even while idle
  assign levelCfg  = {1'b0, pinCfgThree & ~intCtrlFf[0], pinCfgThree & ~intCtrlFf[1], 4'h0, ~intCtrlFf[2]};

  // --------------------
  // event map
  // --------------------
  always_comb begin
    logic [7:0] evt;
    evt = 8'h00;
    evt[VIC_SRC_EXTTOP] = intCtrlFf[2] & extEdge[2];
    evt[VIC_SRC_MBWR]   = mbWrAny;
    evt[VIC_SRC_MBRD]   = mbRdAny;
    evt[VIC_SRC_ATX]    = portATxReq;
    evt[VIC_SRC_ARX]    = portARxReq;
    evt[VIC_SRC_BTX]    = pinCfgThree ? intCtrlFf[1] & extEdge[1] : portBTxReq;
    evt[VIC_SRC_BRX]    = pinCfgThree ? intCtrlFf[0] & extEdge[0] : portBRxReq;
    evt[VIC_SRC_TIMER]  = timerReq;
    rawReq = evt;
  end

  // --------------------
  // edge latch
  // --------------------
  // edge latch: set wins over clear and over service entry
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latchFf <= 8'h00;
    end else begin
      latchFf <= ((latchFf & ~(clearBits & 8'hF9) & ~((ackCmd && canTake) ? (8'h01 << winSlot) : 8'h00))
                 | rawReq | (forceBits & 8'hF9 & ~levelCfg)) & slotAvail;
    end
  end

  // ----------------------------------------
  // priority and service
  // ----------------------------------------
  assign masked = (latchFf | levelSlot) & intMaskFf & slotAvail;

  // scan from lowest priority: last hit wins
  always_comb begin
    winSlot  = 3'd0;
    winValid = 1'b0;
    for (int i = `VIC_NSRC - 1; i >= 0; i--) begin
      if (masked[i]) begin
        winSlot  = 3'(i);
        winValid = 1'b1;
      end
    end
  end

  // --------------------
  // acceptance
  // --------------------
  // nest: only strictly higher than every active; sequential: none active
  always_comb begin
    canTake = winValid && (spFf < depth);
    if (intCtrlFf[`VIC_NEST_BIT]) begin
      for (int i = 0; i < `VIC_NSRC; i++) begin
        if (activeFf[i] && 3'(i) <= winSlot) canTake = 1'b0;
      end
    end else if (activeFf != 8'h00) begin
      canTake = 1'b0;
    end
  end
  assign intPending = canTake;

  // --------------------
  // service and stack
  // --------------------
  // full stack refuses the ack, overflow stays sticky
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      spFf      <= 4'h0;
      activeFf  <= 8'h00;
      vecFf     <= `VIC_VEC_RESET;
      vecLoadFf <= 1'b0;
      ovfFf     <= 1'b0;
    end else begin
      vecLoadFf <= 1'b0;
      if (ackCmd && canTake) begin
        stackMem[spFf] <= {arithFf, modeFf, intMaskFf};
        spFf           <= spFf + 4'h1;
        activeFf[winSlot] <= 1'b1;
        vecFf          <= slotVector(winSlot, variant);
        vecLoadFf      <= 1'b1;
      end else if (ackCmd && winValid && spFf >= depth) begin
        ovfFf <= 1'b1;
      end else if (rtiCmd && spFf != 4'h0) begin
        spFf <= spFf - 4'h1;
        // highest active preempted last, so retires first
        for (int i = 0; i < `VIC_NSRC; i++) begin
          if (activeFf[i] && (activeFf & ((8'h01 << i) - 8'h01)) == 8'h00) activeFf[i] <= 1'b0;
        end
      end
    end
  end

  // --------------------
  // outputs
  // --------------------
  assign vectorAddr = vecFf;
  assign vectorLoad = vecLoadFf;
  assign stackLevel = spFf;
  assign stackOvf   = ovfFf;

  // ----------------------------------------
  // mailbox status
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mbWrFullFf <= 6'h00;
      mbRdDoneFf <= 6'h00;
      swResetFf  <= 1'b0;
    end else begin
      // a write landing with a read re-arms full
      mbWrFullFf <= (mbWrFullFf & ~hostRdStb) | hostWrStb;
      mbRdDoneFf <= (mbRdDoneFf & ~hostWrStb) | hostRdStb;
      if (hostSwRstSet || doWrite && regHit(awAddrFf, `VIC_OFF_MBSTAT7) && wDataFf[`VIC_SWRST_BIT])
        swResetFf <= 1'b1;
      else if (doWrite && regHit(awAddrFf, `VIC_OFF_MBSTAT7))
        swResetFf <= 1'b0;
    end
  end
  assign swReset = swResetFf;
endmodule : vic_ctrl

//--- sim/vic_ctrl_props.sv
// assertion checker on the ports of the vectored interrupt controller
`timescale 1ns/10ps
module vic_ctrl_props (
  input wire logic                  sys_clk,      // core clock
  input wire logic                  rst_n,        // async reset
  input wire vic_pkg::vic_variant_t variant,      // variant strap
  input wire logic                  hostSwRstSet, // host sw reset
  input wire logic                  intPending,   // takeable request
  input wire logic [13:0]           vectorAddr,   // taken vector
  input wire logic                  vectorLoad,   // pc load pulse
  input wire logic [3:0]            stackLevel,   // stack fill
  input wire logic                  swReset       // sw reset level
);
  import vic_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------
  // properties
  // ------------------------------
  load_pulse_a: assert property (vectorLoad |=> !vectorLoad)
    else $error("vector load too long");
  vec_slot_a: assert property (vectorLoad |-> vectorAddr[1:0] == 2'b00 && vectorAddr != 14'h0000)
    else $error("vector off slot grid");
  vec_top_a: assert property (vectorLoad |-> vectorAddr <= (variant == VIC_VAR_MBOX ? 14'h0020 : 14'h0018))
    else $error("vector past lowest slot");
  single_vec_a: assert property (vectorLoad && variant == VIC_VAR_SINGLE |-> vectorAddr[4:3] != 2'b01)
    else $error("absent port vector taken");
  load_cause_a: assert property (vectorLoad |-> $past(intPending))
    else $error("load without request");
  stack_push_a: assert property (vectorLoad && $past(stackLevel) < 4'h7 |-> stackLevel == $past(stackLevel) + 4'h1)
    else $error("no push on load");
  stack_grow_a: assert property (stackLevel > $past(stackLevel) |-> vectorLoad)
    else $error("push without load");
  stack_depth_a: assert property (stackLevel <= (variant == VIC_VAR_MBOX ? 4'h9 : 4'h7))
    else $error("stack beyond depth");
  swrst_set_a: assert property (hostSwRstSet |=> swReset)
    else $error("host reset not set");
  cover property (vectorLoad && stackLevel == 4'h2);
  cover property (vectorLoad && variant == VIC_VAR_MBOX && vectorAddr == 14'h0008);
  cover property ($rose(swReset));
endmodule : vic_ctrl_props

bind vic_ctrl vic_ctrl_props vic_ctrl_props_i (.sys_clk, .rst_n, .variant, .hostSwRstSet, .intPending, .vectorAddr,
  .vectorLoad, .stackLevel, .swReset);

//--- sim/vic_src_model.sv
// behavioural interrupt sources and peripherals around the controller
`timescale 1ns/10ps
module vic_src_model #(
  parameter int MB_REG = 3 // mailbox data register used by the host
) (
  input  wire logic       sys_clk,     // clock
  input  wire logic       pinCfgThree, // port b pins as ext lines
  input  wire logic [7:0] fire,        // one-shot per slot
  input  wire logic       lvlTop,      // hold top line low
  output logic            extIntTop_n, // top line
  output logic            extInt1_n,   // line 1
  output logic            extInt0_n,   // line 0
  output logic            timerReq,    // timer
  output logic            portATxReq,  // port a tx
  output logic            portARxReq,  // port a rx
  output logic            portBTxReq,  // port b tx
  output logic            portBRxReq,  // port b rx
  output logic [5:0]      hostWrStb,   // host writes
  output logic [5:0]      hostRdStb    // host reads
);
  logic [7:0] fireNow = 8'h00;
  logic [7:0] fireDly = 8'h00;
  always @(posedge sys_clk) begin
    fireNow <= fire;
    fireDly <= fireNow;
  end
  // ------------------------------
  // pins: ext lines low two cycles so an edge outlives a synchroniser
  // ------------------------------
  assign extIntTop_n = !(lvlTop | fireNow[0] | fireDly[0]);
  assign extInt1_n   = !(pinCfgThree & (fireNow[5] | fireDly[5]));
  assign extInt0_n   = !(pinCfgThree & (fireNow[6] | fireDly[6]));
  assign timerReq    = fireNow[7];
  assign portATxReq  = fireNow[3];
  assign portARxReq  = fireNow[4];
  assign portBTxReq  = fireNow[5] & !pinCfgThree;
  assign portBRxReq  = fireNow[6] & !pinCfgThree;
  assign hostWrStb   = fireNow[1] ? 6'(6'h01 << MB_REG) : 6'h00;
  assign hostRdStb   = fireNow[2] ? 6'(6'h01 << MB_REG) : 6'h00;
endmodule : vic_src_model

//--- sim/vic_ctrl_test.sv
// self-checking bench of the vectored interrupt controller
`timescale 1ns/10ps
`include "vic_cfg.svh"
module vic_ctrl_test;
  import vic_pkg::*;
  logic         sys_clk = 1'b0, rst_n = 1'b0, pinCfgThree = 1'b0, hostSwRstSet = 1'b0, lvlTop = 1'b0;
  logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0]  s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0]  s_axi_wdata = 32'h00000000, lastVec = 32'h00000000, s_axi_rdata, rd;
  logic [7:0]   fire = 8'h00;
  vic_variant_t variant = VIC_VAR_STD;
  logic         extIntTop_n, extInt1_n, extInt0_n, timerReq, portATxReq, portARxReq, portBTxReq, portBRxReq;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic         intPending, vectorLoad, swReset, stackOvf;
  logic [5:0]   hostWrStb, hostRdStb;
  logic [1:0]   s_axi_rresp, lastResp, s_axi_bresp, lastBResp;
  logic [13:0]  vectorAddr;
  logic [3:0]   stackLevel;
  int           errCount = 0, checksDone = 0, loads = 0;

  vic_src_model vic_src_model_i (.sys_clk, .pinCfgThree, .fire, .lvlTop, .extIntTop_n, .extInt1_n, .extInt0_n,
    .timerReq, .portATxReq, .portARxReq, .portBTxReq, .portBRxReq, .hostWrStb, .hostRdStb);
  vic_ctrl vic_ctrl_i (.sys_clk, .rst_n, .variant, .pinCfgThree, .extIntTop_n, .extInt1_n, .extInt0_n, .timerReq,
    .portATxReq, .portARxReq, .portBTxReq, .portBRxReq, .hostWrStb, .hostRdStb, .hostSwRstSet, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .intPending, .vectorAddr, .vectorLoad, .stackLevel, .stackOvf,
    .swReset);

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (vectorLoad === 1'b1) begin
      lastVec <= 32'(vectorAddr);
      loads   <= loads + 1;
    end
  end
  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [31:0] expVec(input vic_variant_t v, input int s);
    if (s == 0) return 32'h00000004;
    return (v == VIC_VAR_MBOX) ? 32'(4 + 4 * s) : 32'(4 * s - 4);
  endfunction : expVec
  function automatic bit present(input vic_variant_t v, input int s);
    return !((v != VIC_VAR_MBOX && s inside {1, 2}) || (v == VIC_VAR_SINGLE && s inside {3, 4}));
  endfunction : present
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic giveVerdict;
    $display("comparisons %0d, mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : giveVerdict
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    lastBResp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : axw
  task automatic axr(input logic [11:0] a, output logic [31:0] d);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    lastResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : axr
  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    axr(a, d);
    chk(d, e);
  endtask : rdChk
  task automatic pulse(input logic [7:0] m);
    fire <= m;
    @(posedge sys_clk);
    fire <= 8'h00;
    repeat (4) @(posedge sys_clk);
  endtask : pulse
  task automatic pendIs(input logic e);
    repeat (4) @(posedge sys_clk);
    chk(32'(intPending), 32'(e));
  endtask : pendIs
  // ack through the core command word; the load lands on the edge after
  task automatic takeInt(input logic [31:0] v, input logic [3:0] lvl);
    int n;
    n = loads;
    axw(`VIC_OFF_CORECMD, 32'h00000001);
    repeat (2) @(posedge sys_clk);
    chk(32'(loads - n), 32'h00000001);
    chk(lastVec, v);
    chk(32'(stackLevel), 32'(lvl));
  endtask : takeInt
  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    for (int p = 0; p < 3; p++) begin
      variant     <= (p == 0) ? VIC_VAR_STD : (p == 1) ? VIC_VAR_SINGLE : VIC_VAR_MBOX;
      pinCfgThree <= (p == 1);
      rst_n       <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      if (p == 0) begin
        rdChk(`VIC_OFF_MASK, 32'h00000000);
        rdChk(`VIC_OFF_CTRL, 32'h00000000);
        chk(32'(vectorAddr), 32'h00000000);
      end
      rdChk(`VIC_OFF_VARIANT, 32'({pinCfgThree, 1'b0, variant, 2'b00}));
      axw(`VIC_OFF_MASK, 32'h000000FF);
      axw(`VIC_OFF_MBMASK, 32'h00000FFF);
      axw(`VIC_OFF_CTRL, 32'h00000007);
      for (int s = 0; s < 8; s++) begin
        pulse(8'(8'h01 << s));
        if (present(variant, s)) begin
          takeInt(expVec(variant, s), 4'h1);
          axw(`VIC_OFF_CORECMD, 32'h00000002);
          chk(32'(stackLevel), 32'h00000000);
        end else begin
          pendIs(1'b0);
        end
      end
    end
    axw(`VIC_OFF_MASK, 32'h0000007F);
    pulse(8'h88);
    takeInt(32'h00000010, 4'h1);
    axw(`VIC_OFF_CORECMD, 32'h00000002);
    pendIs(1'b0);
    axw(`VIC_OFF_ARITH, 32'h0000005A);
    axw(`VIC_OFF_MASK, 32'h000000FF);
    takeInt(32'h00000020, 4'h1);
    pulse(8'h01);
    pendIs(1'b0);
    axw(`VIC_OFF_CTRL, 32'h00000017);
    axw(`VIC_OFF_ARITH, 32'h000000A5);
    takeInt(32'h00000004, 4'h2);
    axw(`VIC_OFF_ARITH, 32'h00000000);
    axw(`VIC_OFF_CORECMD, 32'h00000002);
    rdChk(`VIC_OFF_ARITH, 32'h000000A5);
    axw(`VIC_OFF_CORECMD, 32'h00000002);
    rdChk(`VIC_OFF_ARITH, 32'h0000005A);
    axw(`VIC_OFF_FORCECLR, 32'h00008000);
    pendIs(1'b1);
    axw(`VIC_OFF_FORCECLR, 32'h00000080);
    pendIs(1'b0);
    axw(`VIC_OFF_CTRL, 32'h00000013);
    axw(`VIC_OFF_FORCECLR, 32'h00000300);
    pendIs(1'b0);
    lvlTop <= 1'b1;
    pendIs(1'b1);
    lvlTop <= 1'b0;
    pendIs(1'b0);
    axw(`VIC_OFF_MBMASK, 32'h00000000);
    pulse(8'h02);
    pendIs(1'b0);
    axw(`VIC_OFF_MBMASK, 32'h00000FFF);
    axw(`VIC_OFF_MASK, 32'h000000FD);
    pulse(8'h02);
    pendIs(1'b0);
    axr(`VIC_OFF_MBSTAT6, rd);
    chk(rd & 32'h00000008, 32'h00000008);
    hostSwRstSet <= 1'b1;
    @(posedge sys_clk);
    hostSwRstSet <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rdChk(`VIC_OFF_MBSTAT7, 32'h00000001);
    axw(`VIC_OFF_MBSTAT7, 32'h00000000);
    chk(32'(swReset), 32'h00000000);
    axr(12'h030, rd);
    chk(rd, 32'h00000000);
    chk(32'(lastResp), 32'h00000002);
    axw(12'h030, 32'h00000001);
    chk(32'(lastBResp), 32'h00000002);
    chk(32'(stackOvf), 32'h00000000);
    giveVerdict();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errCount++;
    giveVerdict();
  end
endmodule : vic_ctrl_test
